// >>> enb_pkg.sv
package enb_pkg;

  // Register indices on the plain register port
  localparam logic [7:0] ADDR_SA5 = 8'h00; // Capture, national bit 5
  localparam logic [7:0] ADDR_SA6 = 8'h01; // Capture, national bit 6
  localparam logic [7:0] ADDR_SA7 = 8'h02; // Capture, national bit 7
  localparam logic [7:0] ADDR_SA8 = 8'h03; // Capture, national bit 8
  localparam logic [7:0] ADDR_CTRL = 8'h04; // Controller two link control
  localparam logic [7:0] ADDR_SEL = 8'h05; // Receive-select bits 3..0

  // Control register field positions
  localparam int CTRL_RSVD = 7; // Reserved, reads zero
  localparam int CTRL_AUTO_ABORT_OFF = 6; // No abort on message switch
  localparam int CTRL_FCS_OFF = 5; // Skip receive check sequence
  localparam int CTRL_DUP_DROP = 4; // Drop repeated frames
  localparam int CTRL_FORCE_ABORT = 3; // Send ones continuously
  localparam int CTRL_MSG_TYPE = 0; // 1 message frame, 0 bit message

  // Reset values
  localparam logic [7:0] CAPTURE_RESET = 8'h00; // Capture registers
  localparam logic [7:0] CTRL_RESET = 8'h00; // Control register
  localparam logic [3:0] SEL_RESET = 4'h0; // Receive-select bits

  // Writable mask of the control register (bit 7 held zero)
  localparam logic [7:0] CTRL_WMASK = 8'h7f;

  // Abort pattern: zero then seven ones, sent msb first
  localparam logic [7:0] ABORT_PATTERN = 8'h7f;
  localparam logic [2:0] ABORT_LAST = 3'h7; // Index of last abort bit

  // Multiframe geometry
  localparam logic [3:0] LAST_FRAME = 4'hf; // Frame 15 ends multiframe
  localparam int NAT_BITS = 4; // National positions 5..8
  localparam int CAP_W = 8; // Bits per capture register

  // Received national bits of one frame
  typedef struct packed {
    logic valid; // Frame bits present this cycle, odd or even
    logic [3:0] frame; // Frame number in multiframe
    logic [3:0] bits; // Bits for positions 8..5 (bit0 = pos 5)
  } enb_nat_type;

  // Whole-frame results from the receive controller
  typedef struct packed {
    logic done; // Frame finished this cycle
    logic fcs_ok; // Check sequence matched
    logic same; // Content equals stored buffer
  } enb_rxframe_type;

endpackage

// >>> enb_national_hdlc2.sv
// Operation
// [RULE_01] Capture national bits once per whole multiframe
// [RULE_02] Capture only positions whose select bit set
// [RULE_03] Frame 2 to bit 7, downward
// [RULE_04] Software writes zero to reserved bit 7
// [RULE_05] Bit 6 zero: abort on message switch; code uses bit 6 as held before the switching write
// [RULE_06] Bit 6 one: no abort on switch; code uses bit 6 as held before the switching write
// [RULE_07] Bit 5 zero: check receive sequence
// [RULE_08] Bit 4 one: drop duplicate frames
// [RULE_09] Bit 3 one: send continuous ones
// [RULE_10] Bit 0 picks message or bit type
// [RULE_11] Shadow copy moves whole at multiframe end
`timescale 1ns/1ns
`default_nettype none

module enb_national_hdlc2 (
  input wire logic i_clock, // 250 MHz clock
  input wire logic i_rst_b, // Async reset, active low
  input wire logic [7:0] i_addr, // Register index
  input wire logic [7:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [7:0] o_rdata, // Read data, cycle after strobe
  input wire enb_pkg::enb_nat_type i_nat, // Received national bits
  input wire enb_pkg::enb_rxframe_type i_rxf, // Receive frame result
  input wire logic i_tx_bit_req, // Transmit wants one line bit
  input wire logic i_tx_data_bit, // Normal controller data bit
  output logic o_tx_bit, // Bit toward the line
  output logic o_tx_abort, // Abort pattern in progress
  output logic o_rx_accept, // Received frame kept
  output logic o_rx_discard, // Received frame dropped
  output logic o_tx_msg_type, // 1 message frame, 0 bit message
  output logic o_rx_fcs_check // Check sequence in use
);

  // All block state in one record
  typedef struct packed {
    logic [enb_pkg::NAT_BITS-1:0][enb_pkg::CAP_W-1:0] shadow; // Gathering
    logic [enb_pkg::NAT_BITS-1:0][enb_pkg::CAP_W-1:0] cap; // Readable
    logic [7:0] ctrl; // Link control
    logic [3:0] sel; // Receive-select bits
    logic [7:0] rdata; // Read data
    logic abort_run; // Abort pattern sending
    logic [2:0] abort_idx; // Bit index in abort pattern
    logic prev_type; // Message type last cycle
    logic tx_bit; // Line bit
    logic rx_accept; // Frame kept pulse
    logic rx_discard; // Frame dropped pulse
    logic fcs_check; // Receive check in use, own flop
  } enb_state_type;

  enb_state_type state_q; // Registered state
  enb_state_type state_d; // Next state

  // Reset image of the state
  localparam enb_state_type STATE_RESET = '{
    shadow: '0,
    cap: '0,
    ctrl: enb_pkg::CTRL_RESET,
    sel: enb_pkg::SEL_RESET,
    rdata: 8'h00,
    abort_run: 1'b0,
    abort_idx: 3'h0,
    prev_type: 1'b0,
    tx_bit: 1'b1,
    rx_accept: 1'b0,
    rx_discard: 1'b0,
    fcs_check: 1'b1
  };

  // Capture slot for the current frame: frame 2 -> bit 7 etc.
  logic [2:0] slot; // Bit position for this even frame
  assign slot = 3'(3'h7 - 3'(i_nat.frame[3:1] - 3'h1)); // see [RULE_03]

  // Next-state logic
  always_comb begin
    logic new_type; // Message type after any write
    logic to_bit; // Switch from message to bit type
    state_d = state_q;
    new_type = state_q.ctrl[enb_pkg::CTRL_MSG_TYPE];
    to_bit = 1'b0;
    state_d.rx_accept = 1'b0;
    state_d.rx_discard = 1'b0;

    // Register writes
    if (i_wr) begin
      if (i_addr == enb_pkg::ADDR_CTRL) begin
        // Reserved bit held zero whatever is written, see [RULE_04]
        state_d.ctrl = i_wdata & enb_pkg::CTRL_WMASK;
      end else if (i_addr == enb_pkg::ADDR_SEL) begin
        state_d.sel = i_wdata[3:0];
      end
    end

    // Register reads, answered next cycle
    if (i_rd) begin
      if (i_addr == enb_pkg::ADDR_SA5) begin
        state_d.rdata = state_q.cap[0];
      end else if (i_addr == enb_pkg::ADDR_SA6) begin
        state_d.rdata = state_q.cap[1];
      end else if (i_addr == enb_pkg::ADDR_SA7) begin
        state_d.rdata = state_q.cap[2];
      end else if (i_addr == enb_pkg::ADDR_SA8) begin
        state_d.rdata = state_q.cap[3];
      end else if (i_addr == enb_pkg::ADDR_CTRL) begin
        state_d.rdata = state_q.ctrl;
      end else if (i_addr == enb_pkg::ADDR_SEL) begin
        state_d.rdata = {4'h0, state_q.sel};
      end else begin
        // Unmapped index reads zero
        state_d.rdata = 8'h00;
      end
    end else begin
      state_d.rdata = 8'h00;
    end

    // National bit gathering into the shadow
    if (i_nat.valid && !i_nat.frame[0]) begin
      for (int p = 0; p < enb_pkg::NAT_BITS; p++) begin
        state_d.shadow[p][slot] = i_nat.bits[p]; // see [RULE_11]
      end
    end
    // Whole multiframe seen: copy selected positions at once
    if (i_nat.valid && i_nat.frame == enb_pkg::LAST_FRAME) begin
      for (int p = 0; p < enb_pkg::NAT_BITS; p++) begin
        if (state_q.sel[p]) begin // see [RULE_02]
          state_d.cap[p] = state_d.shadow[p]; // see [RULE_01]
        end
      end
    end

    // Transmit type tracking; switch seen on the write that clears it
    new_type = state_d.ctrl[enb_pkg::CTRL_MSG_TYPE]; // see [RULE_10]
    to_bit = state_q.prev_type && !new_type;
    state_d.prev_type = new_type;
    // Abort on switch only if automatic abort was enabled before this write
    if (to_bit && !state_q.ctrl[enb_pkg::CTRL_AUTO_ABORT_OFF]) begin
      state_d.abort_run = 1'b1; // see [RULE_05]
      state_d.abort_idx = 3'h0;
    end
    // With automatic abort off before the write, the switch is passed silently, see [RULE_06]

    // Line bit generation
    if (i_tx_bit_req) begin
      if (state_q.ctrl[enb_pkg::CTRL_FORCE_ABORT]) begin
        // Forced abort: continuous ones, see [RULE_09]
        state_d.tx_bit = 1'b1;
      end else if (state_q.abort_run) begin
        state_d.tx_bit = enb_pkg::ABORT_PATTERN[
          3'(enb_pkg::ABORT_LAST - state_q.abort_idx)]; // see [RULE_05]
        state_d.abort_idx = 3'(state_q.abort_idx + 3'h1);
        if (state_q.abort_idx == enb_pkg::ABORT_LAST) begin
          state_d.abort_run = 1'b0;
        end
      end else begin
        state_d.tx_bit = i_tx_data_bit;
      end
    end

    // Check flag kept in a flop so the output has no gate after it
    state_d.fcs_check = !state_d.ctrl[enb_pkg::CTRL_FCS_OFF]; // see [RULE_07]

    // Receive frame verdict
    if (i_rxf.done) begin
      if (!state_q.ctrl[enb_pkg::CTRL_FCS_OFF] && !i_rxf.fcs_ok) begin
        // Bad check sequence only counts while checking, see [RULE_07]
        state_d.rx_discard = 1'b1;
      end else if (state_q.ctrl[enb_pkg::CTRL_DUP_DROP] && i_rxf.same) begin
        // Repeat of stored content dropped, see [RULE_08]
        state_d.rx_discard = 1'b1;
      end else begin
        state_d.rx_accept = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flops
  assign o_rdata = state_q.rdata;
  assign o_tx_bit = state_q.tx_bit;
  assign o_tx_abort = state_q.abort_run;
  assign o_rx_accept = state_q.rx_accept;
  assign o_rx_discard = state_q.rx_discard;
  assign o_tx_msg_type = state_q.ctrl[enb_pkg::CTRL_MSG_TYPE];
  assign o_rx_fcs_check = state_q.fcs_check;

endmodule

`default_nettype wire

// >>> enb_national_hdlc2_checker.sv
`timescale 1ns/1ns
`default_nettype none
module enb_national_hdlc2_checker (
  input wire logic i_clock, // Clock
  input wire logic i_rst_b, // Reset, active low
  input wire logic [7:0] i_addr, // Register index
  input wire logic i_rd, // Read strobe
  input wire logic [7:0] o_rdata, // Read data
  input wire enb_pkg::enb_rxframe_type i_rxf, // Frame result
  input wire logic i_tx_bit_req, // Bit wanted
  input wire logic o_tx_bit, // Line bit
  input wire logic o_tx_abort, // Auto abort pending
  input wire logic o_rx_accept, // Frame kept
  input wire logic o_rx_discard, // Frame dropped
  input wire logic o_tx_msg_type, // Message type out
  input wire logic o_rx_fcs_check // Check in use
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // Control read; its data stands one cycle later
  sequence ctrl_rd;
    i_rd && i_addr == enb_pkg::ADDR_CTRL;
  endsequence
  rsvd_zero_a:
    assert property (ctrl_rd |=> !o_rdata[7])
    else $error("reserved control bit reads one");
  fcs_flag_a:
    assert property (ctrl_rd |=> o_rdata[5] != o_rx_fcs_check)
    else $error("check flag disagrees with control");
  msg_type_a:
    assert property (ctrl_rd |=> o_rdata[0] == o_tx_msg_type)
    else $error("message type disagrees with control");
  force_ones_a:
    assert property (ctrl_rd ##1 (o_rdata[3] && i_tx_bit_req) |=> o_tx_bit)
    else $error("forced abort sent a zero");
  abort_off_a:
    assert property (ctrl_rd ##1 o_rdata[6] |-> !o_tx_abort)
    else $error("abort pending while disabled");
  keep_good_a:
    assert property (i_rxf.done && i_rxf.fcs_ok && !i_rxf.same
    |=> o_rx_accept && !o_rx_discard)
    else $error("good new frame not kept");
  fcs_bad_a:
    assert property (i_rxf.done && !i_rxf.fcs_ok && o_rx_fcs_check
    |=> o_rx_discard && !o_rx_accept)
    else $error("bad check sequence not dropped");
  no_result_a:
    assert property (!i_rxf.done |=> !(o_rx_accept || o_rx_discard))
    else $error("frame result without a frame");
endmodule
bind enb_national_hdlc2 enb_national_hdlc2_checker u_chk (.*);
`default_nettype wire

// >>> enb_far_model.sv
`timescale 1ns/1ns
`default_nettype none
module enb_far_model (
  input wire logic i_clock, // Clock
  output var enb_pkg::enb_nat_type o_nat, // National bits
  output var enb_pkg::enb_rxframe_type o_rxf // Frame result
);
  logic [3:0] b; // Bits of the frame being sent
  initial begin
    o_nat = '0;
    o_rxf = '0;
  end
  // One multiframe; byte p of sa is what position p should capture
  task automatic mf(input logic [31:0] sa);
    for (int f = 0; f < 16; f++) begin
      // Frame 2 carries byte bit 7, frame 4 bit 6
      for (int p = 0; p < 4; p++) b[p] = sa[p * 8 + (8 - f / 2) % 8];
      @(posedge i_clock);
      o_nat <= {1'b1, f[3:0], f[0] ? ~b : b}; // Odd frames carry junk
      @(posedge i_clock);
      o_nat <= {1'b0, f[3:0], ~b}; // Stale bits turned round between frames
    end
  endtask
  // One received frame with its check and duplicate results
  task automatic frame(input logic ok, input logic same);
    @(posedge i_clock);
    o_rxf <= {1'b1, ok, same};
    @(posedge i_clock);
    o_rxf <= '0;
  endtask
endmodule
`default_nettype wire

// >>> enb_national_hdlc2_tb.sv
`timescale 1ns/1ns
`default_nettype none
module enb_national_hdlc2_tb;
  logic i_clock, i_rst_b, i_wr, i_rd, i_tx_bit_req, i_tx_data_bit, o_tx_bit;
  logic o_tx_abort, o_rx_accept, o_rx_discard, o_tx_msg_type, o_rx_fcs_check;
  logic [7:0] i_addr, i_wdata, o_rdata; // Register port
  enb_pkg::enb_nat_type i_nat; // National bits from far side
  enb_pkg::enb_rxframe_type i_rxf; // Frame results from far side
  int err_count, checks_done;
  enb_national_hdlc2 dut (.*);
  enb_far_model far (.i_clock, .o_nat(i_nat), .o_rxf(i_rxf));
  initial begin i_clock = 0; forever #2 i_clock = ~i_clock; end
  task automatic chk(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bus cycles; an idle edge first keeps strobes from being set twice
  task automatic wr(input logic [7:0] a, d);
    @(posedge i_clock);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp, input string what);
    @(posedge i_clock);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk(what, o_rdata, exp);
  endtask
  // Control read, then one line bit in the cycle its data stands
  task automatic tx(input logic [7:0] c, input logic d, exp);
    @(posedge i_clock);
    {i_rd, i_addr} <= {1'b1, enb_pkg::ADDR_CTRL};
    @(posedge i_clock);
    i_rd <= 1'b0;
    {i_tx_bit_req, i_tx_data_bit} <= {1'b1, d};
    #1 chk("control", o_rdata, c);
    @(posedge i_clock);
    i_tx_bit_req <= 1'b0;
    #1 chk("line bit", {7'h00, o_tx_bit}, {7'h00, exp});
  endtask
  task automatic t_reset;
    for (int a = 0; a < 7; a++) rd(a[7:0], 8'h00, "reset value");
    chk("idle line", {7'h00, o_tx_bit}, 8'h01);
  endtask
  // Unselected positions stay clear; read-only writes are ignored
  task automatic t_capture;
    wr(enb_pkg::ADDR_SEL, 8'h05);
    far.mf(32'he1963ca5);
    wr(enb_pkg::ADDR_SA5, 8'h00);
    for (int p = 0; p < 4; p++)
      rd(p[7:0], p[0] ? 8'h00 : 8'(32'he1963ca5 >> (p * 8)),
        "capture");
    wr(enb_pkg::ADDR_SEL, 8'h0f);
    far.mf(32'h5a0f3c81);
    for (int p = 0; p < 4; p++)
      rd(p[7:0], 8'(32'h5a0f3c81 >> (p * 8)), "capture");
  endtask
  task automatic t_ctrl;
    wr(enb_pkg::ADDR_CTRL, 8'hff);
    rd(enb_pkg::ADDR_CTRL, 8'h7f, "control");
    chk("msg type", {7'h00, o_tx_msg_type}, 8'h01);
    chk("fcs check", {7'h00, o_rx_fcs_check}, 8'h00);
  endtask
  // Every mix of check-off, duplicate drop, check result and match
  task automatic t_rx;
    logic d;
    for (int k = 0; k < 16; k++) begin
      wr(enb_pkg::ADDR_CTRL, {2'h0, k[3], k[2], 4'h0});
      far.frame(k[1], k[0]);
      d = (!k[3] && !k[1]) || (k[2] && k[0]);
      #1 chk("rx result", {o_rx_accept, o_rx_discard}, {!d, d});
    end
  endtask
  task automatic t_abort;
    wr(enb_pkg::ADDR_CTRL, 8'h08);
    tx(8'h08, 1'b0, 1'b1);
    wr(enb_pkg::ADDR_CTRL, 8'h01);
    tx(8'h01, 1'b0, 1'b0);
    wr(enb_pkg::ADDR_CTRL, 8'h00);
    #1 chk("abort flag", {7'h00, o_tx_abort}, 8'h01);
    for (int i = 0; i < 9; i++)
      tx(8'h00, i == 0, i != 0 && i != 8);
    chk("abort done", {7'h00, o_tx_abort}, 8'h00);
    wr(enb_pkg::ADDR_CTRL, 8'h41);
    wr(enb_pkg::ADDR_CTRL, 8'h40);
    #1 chk("no abort", {7'h00, o_tx_abort}, 8'h00);
    tx(8'h40, 1'b1, 1'b1);
    tx(8'h40, 1'b0, 1'b0);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {i_rst_b, i_wr, i_rd, i_tx_bit_req, i_tx_data_bit} = '0;
    {i_addr, i_wdata, err_count, checks_done} = '0;
    repeat (10) @(posedge i_clock);
    i_rst_b <= 1'b1;
    t_reset;
    t_capture;
    t_ctrl;
    t_rx;
    t_abort;
    tally_and_finish;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge i_clock);
    err_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
